// ==== pkg/tdd_regs.svh ====
// Descriptor field positions, register offsets and reset values
`ifndef TDD_REGS_SVH
`define TDD_REGS_SVH

// Dword 0 fields
`define TDD_KSP_HI        31
`define TDD_KSP_LO        6
`define TDD_BLK_HI        3
`define TDD_BLK_LO        0

// Dword 1 fields
`define TDD_CLEN_HI       31
`define TDD_CLEN_LO       26
`define TDD_COFS_HI       25
`define TDD_COFS_LO       20
`define TDD_SPF_BIT       18
`define TDD_PRIO_BIT      17
`define TDD_FP_BIT        16
`define TDD_ILL_BIT       13
`define TDD_MSK_BIT       11
`define TDD_SWE_BIT       7

// Thread control word positions
`define TDD_TCW_ILL       12
`define TDD_TCW_MSK       11
`define TDD_TCW_SWE       13

// Remap applies to indices 0 up to this value
`define TDD_REMAP_LAST    5'h0F

// Register offsets (byte addresses), remap window select for address bits 7:6, control enable bit
`define TDD_REG_CTRL      8'h00
`define TDD_REG_GSBASE    8'h04
`define TDD_REG_STATUS    8'h08
`define TDD_REG_COUNT     8'h0C
`define TDD_REG_REMAP_SEL 2'h1
`define TDD_CTRL_EXT_BIT  0

// Reset values
`define TDD_CTRL_RST      1'h0
`define TDD_GSBASE_RST    32'h0000_0000

// Cycles from launch to dispatch pulse
`define TDD_DISP_LAT      1

`endif

// ==== pkg/tdd_pkg.sv ====
// Types shared by both ends of the thread descriptor link
`default_nettype none

package tdd_pkg;

    typedef logic [4:0]  tdd_index_type;
    typedef logic [31:0] tdd_dword_type;

    typedef struct packed {
        logic          ext_sel;
        logic [31:0]   gs_base;
        tdd_index_type last_index;
        logic          last_remapped;
        logic [15:0]   launch_count;
        logic [31:0]   rdata;
        logic          disp_valid;
        tdd_index_type disp_index;
        logic [31:0]   disp_fetch_addr;
        logic [4:0]    disp_reg_blocks;
        logic [5:0]    disp_const_len;
        logic [5:0]    disp_const_ofs;
        logic          disp_single_flow;
        logic          disp_fp_alt;
        logic [15:0]   disp_thread_ctrl;
    } tdd_dev_state_type;

    typedef struct packed {
        logic          store_valid;
        tdd_index_type store_index;
        tdd_dword_type store_dw0;
        tdd_dword_type store_dw1;
        logic          launch_valid;
        tdd_index_type launch_index;
    } tdd_host_state_type;

endpackage

`default_nettype wire

// ==== pkg/tdd_link_if.sv ====
// Link between the record builder and the descriptor decoder
`timescale 1ns/1ps
`default_nettype none

interface tdd_link_if;
    import tdd_pkg::*;

    logic          store_valid;
    tdd_index_type store_index;
    tdd_dword_type store_dw0;
    tdd_dword_type store_dw1;
    logic          launch_valid;
    tdd_index_type launch_index;

    modport host (
        output store_valid,
        output store_index,
        output store_dw0,
        output store_dw1,
        output launch_valid,
        output launch_index
    );

    modport dev (
        input  store_valid,
        input  store_index,
        input  store_dw0,
        input  store_dw1,
        input  launch_valid,
        input  launch_index
    );

endinterface

`default_nettype wire

// ==== hdl/tdd_device.sv ====
// Thread descriptor decoder: remap, table, field decode, dispatch
//
// Function
// - Extended state, index 0-15: remap index
// - No extended state: use index directly
// - Dword0 31:6 plus base gives fetch
// - Dword0 3:0 is block count minus one
// - Builder keeps block field LSB zero
// - Builder rounds registers up to eight
// - Dword1 31:26 length; zero ignores offset
// - Dword1 25:20 is constant read offset
// - Bit 18 one selects single flow
// - Builder writes priority bit as zero
// - Bit 16 selects IEEE or alternate
// - Bit 13 goes to control bit 12
// - Bit 11 goes to control bit 11
// - Bit 7 goes to control bit 13
// - Builder keeps kernels below 4G
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tdd_regs.svh"

module tdd_device (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Link from the record builder
    tdd_link_if.dev                  link,
    // Software register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    // Dispatch parameters toward the execution cores
    output logic                     disp_valid,
    output tdd_pkg::tdd_index_type   disp_index,
    output logic [31:0]              disp_fetch_addr,
    output logic [4:0]               disp_reg_blocks,
    output logic [5:0]               disp_const_len,
    output logic [5:0]               disp_const_ofs,
    output logic                     disp_single_flow,
    output logic                     disp_fp_alt,
    output logic [15:0]              disp_thread_ctrl
);
    import tdd_pkg::*;

    tdd_dev_state_type s_q;
    tdd_dev_state_type s_d;

    // Descriptor table and remap table
    // Tables are not reset: an unstored slot reads unknown data
    tdd_dword_type dw0_mem [0:31];
    tdd_dword_type dw1_mem [0:31];
    tdd_index_type remap_mem [0:15];

    logic          remap_hit;
    tdd_index_type use_index;
    tdd_dword_type dw0;
    tdd_dword_type dw1;
    logic          remap_wr;
    logic [3:0]    remap_sel;
    logic [31:0]   rd_word;

    // Fields of the resolved record
    logic [25:0]   kernel_ofs;
    logic [3:0]    blk_code;
    logic [5:0]    const_len;
    logic [5:0]    const_ofs;
    logic          flow_bit;
    logic          fp_bit;
    logic [15:0]   tcw;

    // Remap entry n sits at byte offset 40h plus four times n
    assign remap_sel = reg_addr[5:2];
    assign remap_wr  = reg_wr && (reg_addr[7:6] == `TDD_REG_REMAP_SEL);

    // Only defined fields are pulled out; reserved bits go nowhere
    assign kernel_ofs = dw0[`TDD_KSP_HI:`TDD_KSP_LO];
    assign blk_code   = dw0[`TDD_BLK_HI:`TDD_BLK_LO];
    assign const_len  = dw1[`TDD_CLEN_HI:`TDD_CLEN_LO];
    assign const_ofs  = dw1[`TDD_COFS_HI:`TDD_COFS_LO];
    assign flow_bit   = dw1[`TDD_SPF_BIT];
    assign fp_bit     = dw1[`TDD_FP_BIT];

    // Thread control word; the illegal and software enables land on shifted positions
    for (genvar b = 0; b < 16; b++) begin : g_tcw
        if (b == `TDD_TCW_ILL) begin : g_ill
            assign tcw[b] = dw1[`TDD_ILL_BIT];
        end else if (b == `TDD_TCW_MSK) begin : g_msk
            assign tcw[b] = dw1[`TDD_MSK_BIT];
        end else if (b == `TDD_TCW_SWE) begin : g_swe
            assign tcw[b] = dw1[`TDD_SWE_BIT];
        end else begin : g_zero
            assign tcw[b] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (link.store_valid) begin
            dw0_mem[link.store_index] <= link.store_dw0;
            dw1_mem[link.store_index] <= link.store_dw1;
        end
        if (remap_wr) begin
            remap_mem[remap_sel] <= reg_wdata[4:0];
        end
    end

    // Index resolution
    always_comb begin
        remap_hit = s_q.ext_sel
                    && (link.launch_index <= `TDD_REMAP_LAST);
        if (remap_hit) begin
            use_index = remap_mem[link.launch_index[3:0]];
        end else begin
            use_index = link.launch_index;
        end
        dw0 = dw0_mem[use_index];
        dw1 = dw1_mem[use_index];
    end

    // Read mux, kept apart so that the strobe alone gates the data
    always_comb begin
        rd_word = 32'h0000_0000;
        if (reg_addr == `TDD_REG_CTRL) begin
            rd_word[`TDD_CTRL_EXT_BIT] = s_q.ext_sel;
        end else if (reg_addr == `TDD_REG_GSBASE) begin
            rd_word = s_q.gs_base;
        end else if (reg_addr == `TDD_REG_STATUS) begin
            rd_word[4:0] = s_q.last_index;
            rd_word[8]   = s_q.last_remapped;
        end else if (reg_addr == `TDD_REG_COUNT) begin
            rd_word[15:0] = s_q.launch_count;
        end else if (reg_addr[7:6] == `TDD_REG_REMAP_SEL) begin
            rd_word[4:0] = remap_mem[remap_sel];
        end
    end

    always_comb begin
        s_d            = s_q;
        s_d.disp_valid = 1'b0;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `TDD_REG_CTRL) begin
                s_d.ext_sel = reg_wdata[`TDD_CTRL_EXT_BIT];
            end else if (reg_addr == `TDD_REG_GSBASE) begin
                s_d.gs_base = reg_wdata;
            end
        end

        // Register reads, data stand in the following cycle only
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            s_d.rdata = rd_word;
        end

        // Decode; reserved bits are never looked at
        if (link.launch_valid) begin
            s_d.disp_valid    = 1'b1;
            s_d.disp_index    = use_index;
            s_d.last_index    = use_index;
            s_d.last_remapped = remap_hit;
            // Count wraps silently after 65535 launches
            s_d.launch_count  = s_q.launch_count + 16'h0001;
            s_d.disp_fetch_addr = s_q.gs_base + {kernel_ofs, 6'h00};
            s_d.disp_reg_blocks = {1'b0, blk_code} + 5'h01;
            s_d.disp_const_len  = const_len;
            if (const_len == 6'h00) begin
                s_d.disp_const_ofs = 6'h00;
            end else begin
                s_d.disp_const_ofs = const_ofs;
            end
            s_d.disp_single_flow = flow_bit;
            s_d.disp_fp_alt      = fp_bit;
            s_d.disp_thread_ctrl = tcw;
        end
    end

    always_ff @(posedge clk) begin
        // Tables keep their contents through reset
        if (rst) begin
            s_q         <= '0;
            s_q.ext_sel <= `TDD_CTRL_RST;
            s_q.gs_base <= `TDD_GSBASE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Read data stand for one cycle after the strobe
    assign reg_rdata        = s_q.rdata;

    // Dispatch pulse lasts one cycle per launch
    assign disp_valid       = s_q.disp_valid;

    // Outputs hold the last dispatch until the next one
    assign disp_index       = s_q.disp_index;
    assign disp_fetch_addr  = s_q.disp_fetch_addr;
    assign disp_reg_blocks  = s_q.disp_reg_blocks;
    assign disp_const_len   = s_q.disp_const_len;
    assign disp_const_ofs   = s_q.disp_const_ofs;
    assign disp_single_flow = s_q.disp_single_flow;
    assign disp_fp_alt      = s_q.disp_fp_alt;
    assign disp_thread_ctrl = s_q.disp_thread_ctrl;

endmodule

`default_nettype wire

// ==== hdl/tdd_host.sv ====
// Record builder: encodes launch records and issues launches
`timescale 1ns/1ps
`default_nettype none
`include "tdd_regs.svh"

module tdd_host (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Record build request
    input  wire logic                bld_store,
    input  wire tdd_pkg::tdd_index_type bld_index,
    input  wire logic [25:0]         bld_kernel_ofs,
    input  wire logic [7:0]          bld_reg_count,
    input  wire logic [5:0]          bld_const_len,
    input  wire logic [5:0]          bld_const_ofs,
    input  wire logic                bld_single_flow,
    input  wire logic                bld_fp_alt,
    input  wire logic                bld_illegal_en,
    input  wire logic                bld_mask_stack_en,
    input  wire logic                bld_sw_en,
    // Launch request
    input  wire logic                go_launch,
    input  wire tdd_pkg::tdd_index_type go_index,
    // Link toward the decoder
    tdd_link_if.host                 link
);
    import tdd_pkg::*;

    tdd_host_state_type s_q;
    tdd_host_state_type s_d;

    logic [4:0] blocks8;
    logic [3:0] enc;
    logic [3:0] enc_even;

    always_comb begin
        // Round up to whole 8-register blocks, zero counts as one
        blocks8 = 5'((9'(bld_reg_count) + 9'h007) >> 3);
        if (blocks8 == 5'h00) begin
            blocks8 = 5'h01;
        end
        enc = 4'(blocks8 - 5'h01);
        // Keep the field LSB clear, rounding up, saturating at 14
        if (enc == 4'hF) begin
            enc_even = 4'hE;
        end else begin
            enc_even = enc + {3'h0, enc[0]};
        end
    end

    always_comb begin
        s_d              = s_q;
        s_d.store_valid  = bld_store;
        s_d.launch_valid = go_launch;
        if (go_launch) begin
            s_d.launch_index = go_index;
        end
        if (bld_store) begin
            s_d.store_index = bld_index;
            // Every reserved bit and the priority bit are left zero
            s_d.store_dw0 = 32'h0000_0000;
            s_d.store_dw1 = 32'h0000_0000;
            // Offset field is bits 31:6 of a 32-bit dword, so kernels sit below 4G
            s_d.store_dw0[`TDD_KSP_HI:`TDD_KSP_LO] = bld_kernel_ofs;
            s_d.store_dw0[`TDD_BLK_HI:`TDD_BLK_LO] = enc_even;
            s_d.store_dw1[`TDD_CLEN_HI:`TDD_CLEN_LO] = bld_const_len;
            s_d.store_dw1[`TDD_COFS_HI:`TDD_COFS_LO] = bld_const_ofs;
            s_d.store_dw1[`TDD_SPF_BIT] = bld_single_flow;
            s_d.store_dw1[`TDD_FP_BIT]  = bld_fp_alt;
            s_d.store_dw1[`TDD_ILL_BIT] = bld_illegal_en;
            s_d.store_dw1[`TDD_MSK_BIT] = bld_mask_stack_en;
            s_d.store_dw1[`TDD_SWE_BIT] = bld_sw_en;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.store_valid  = s_q.store_valid;
    assign link.store_index  = s_q.store_index;
    assign link.store_dw0    = s_q.store_dw0;
    assign link.store_dw1    = s_q.store_dw1;
    assign link.launch_valid = s_q.launch_valid;
    assign link.launch_index = s_q.launch_index;

endmodule

`default_nettype wire

// ==== tb/tdd_properties.sv ====
// Concurrent checks on the descriptor link and the dispatch outputs
`timescale 1ns/1ps
`default_nettype none

module tdd_properties (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // Link
    input wire logic                  store_valid,
    input wire tdd_pkg::tdd_dword_type store_dw0,
    input wire tdd_pkg::tdd_dword_type store_dw1,
    input wire logic                  launch_valid,
    input wire tdd_pkg::tdd_index_type launch_index,
    // Dispatch
    input wire logic                  disp_valid,
    input wire tdd_pkg::tdd_index_type disp_index,
    input wire logic [31:0]           disp_fetch_addr,
    input wire logic [4:0]            disp_reg_blocks,
    input wire logic [5:0]            disp_const_len,
    input wire logic [5:0]            disp_const_ofs,
    input wire logic [15:0]           disp_thread_ctrl
);
    import tdd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_launch_answer: assert property (launch_valid |=> disp_valid)
        else $error("launch without dispatch one cycle later");
    a_no_extra_disp: assert property (!launch_valid |=> !disp_valid)
        else $error("dispatch without launch");
    a_index_bypass: assert property (launch_valid && launch_index > 5'h0F
        |=> disp_index == $past(launch_index))
        else $error("index above fifteen was remapped");
    a_block_range: assert property (disp_valid
        |-> disp_reg_blocks inside {[5'h01:5'h10]})
        else $error("block count out of range");
    a_ofs_ignored: assert property (disp_valid && disp_const_len == 6'h00
        |-> disp_const_ofs == 6'h00)
        else $error("offset used with zero length");
    a_tcw_spare: assert property (disp_valid
        |-> (disp_thread_ctrl & 16'hC7FF) == 16'h0000)
        else $error("stray control word bit");
    a_fetch_hold: assert property (!disp_valid
        |-> $stable(disp_fetch_addr))
        else $error("fetch address moved without dispatch");
    a_even_blocks: assert property (store_valid |-> !store_dw0[0])
        else $error("odd block field sent");
    a_prio_zero: assert property (store_valid |-> !store_dw1[17])
        else $error("priority bit sent set");
    a_rsvd_zero: assert property (store_valid
        |-> (store_dw0 & 32'h0000_0030) == 32'h0000_0000
        && (store_dw1 & 32'h0008_D77F) == 32'h0000_0000)
        else $error("reserved bit sent set");
endmodule

`default_nettype wire

// ==== tb/thread_descriptor_decode_bench.sv ====
// Self-checking bench for the record builder and decoder pair
`timescale 1ns/1ps
`default_nettype none
`include "tdd_regs.svh"

module thread_descriptor_decode_bench;
    import tdd_pkg::*;
    logic          clk, rst, bld_store, go_launch, reg_wr, reg_rd;
    logic          bld_single_flow, bld_fp_alt, bld_illegal_en;
    logic          bld_mask_stack_en, bld_sw_en;
    logic          disp_valid, disp_single_flow, disp_fp_alt;
    tdd_index_type bld_index, go_index, disp_index;
    logic [25:0]   bld_kernel_ofs;
    logic [7:0]    bld_reg_count, reg_addr;
    logic [5:0]    bld_const_len, bld_const_ofs;
    logic [5:0]    disp_const_len, disp_const_ofs;
    logic [31:0]   reg_wdata, reg_rdata, disp_fetch_addr, gs, v;
    logic [4:0]    disp_reg_blocks;
    logic [15:0]   disp_thread_ctrl;
    int            miscompares, n_checks;

    tdd_link_if link ();
    tdd_host i_tdd_host (
        .clk(clk), .rst(rst), .bld_store(bld_store), .bld_index(bld_index),
        .bld_kernel_ofs(bld_kernel_ofs), .bld_reg_count(bld_reg_count),
        .bld_const_len(bld_const_len), .bld_const_ofs(bld_const_ofs),
        .bld_single_flow(bld_single_flow), .bld_fp_alt(bld_fp_alt),
        .bld_illegal_en(bld_illegal_en),
        .bld_mask_stack_en(bld_mask_stack_en), .bld_sw_en(bld_sw_en),
        .go_launch(go_launch), .go_index(go_index), .link(link));
    tdd_device i_tdd_device (
        .clk(clk), .rst(rst), .link(link), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .disp_valid(disp_valid),
        .disp_index(disp_index), .disp_fetch_addr(disp_fetch_addr),
        .disp_reg_blocks(disp_reg_blocks), .disp_const_len(disp_const_len),
        .disp_const_ofs(disp_const_ofs),
        .disp_single_flow(disp_single_flow), .disp_fp_alt(disp_fp_alt),
        .disp_thread_ctrl(disp_thread_ctrl));
    tdd_properties i_tdd_properties (
        .clk(clk), .rst(rst), .store_valid(link.store_valid),
        .store_dw0(link.store_dw0), .store_dw1(link.store_dw1),
        .launch_valid(link.launch_valid), .launch_index(link.launch_index),
        .disp_valid(disp_valid), .disp_index(disp_index),
        .disp_fetch_addr(disp_fetch_addr), .disp_reg_blocks(disp_reg_blocks),
        .disp_const_len(disp_const_len), .disp_const_ofs(disp_const_ofs),
        .disp_thread_ctrl(disp_thread_ctrl));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Store record in slot i, launch li, expect slot i's fields at index ei
    task automatic run(input logic [4:0] i, li, ei, input logic [25:0] k,
                       input logic [7:0] r, input logic [4:0] eb,
                       input logic [5:0] l, o, input logic [4:0] f);
        int n;
        @(posedge clk);
        bld_store <= 1'b1;
        bld_index <= i;
        bld_kernel_ofs <= k;
        bld_reg_count <= r;
        bld_const_len <= l;
        bld_const_ofs <= o;
        {bld_single_flow, bld_fp_alt, bld_illegal_en,
         bld_mask_stack_en, bld_sw_en} <= f;
        @(posedge clk);
        bld_store <= 1'b0;
        go_launch <= 1'b1;
        go_index <= li;
        @(posedge clk);
        go_launch <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (disp_valid !== 1'b1 && n < 6);
        chk("disp_latency", `TDD_DISP_LAT, n);
        if (disp_valid !== 1'b1)
            stop_test();
        chk("index", ei, disp_index);
        chk("fetch", gs + {k, 6'h00}, disp_fetch_addr);
        chk("blocks", eb, disp_reg_blocks);
        chk("clen", l, disp_const_len);
        chk("cofs", (l == 6'h00) ? 6'h00 : o, disp_const_ofs);
        chk("flow", f[4], disp_single_flow);
        chk("fp", f[3], disp_fp_alt);
        chk("tcw_ill", f[2], disp_thread_ctrl[12]);
        chk("tcw_msk", f[1], disp_thread_ctrl[11]);
        chk("tcw_swe", f[0], disp_thread_ctrl[13]);
        chk("tcw_spare", 32'h0, disp_thread_ctrl & 16'hC7FF);
    endtask

    task automatic t_regs();
        rd(`TDD_REG_CTRL, v);
        chk("ctrl", 32'h0, v);
        rd(`TDD_REG_GSBASE, v);
        chk("gsbase", 32'h0, v);
        rd(8'h20, v);
        chk("unmapped", 32'h0, v);
        gs = 32'h8765_4000;
        wr(`TDD_REG_GSBASE, gs);
        rd(`TDD_REG_GSBASE, v);
        chk("gsbase_back", gs, v);
        $display("test regs done");
    endtask

    // Rounding of register counts, zero length, every flag both ways
    task automatic t_fields();
        run(5'h14, 5'h14, 5'h14, 26'h000_0011, 8'h09, 5'h03, 6'h3F, 6'h2A,
            5'h15);
        run(5'h15, 5'h15, 5'h15, 26'h3FF_FFC0, 8'h80, 5'h0F, 6'h00, 6'h3F,
            5'h0A);
        run(5'h16, 5'h16, 5'h16, 26'h000_0001, 8'h01, 5'h01, 6'h01, 6'h00,
            5'h1F);
        $display("test fields done");
    endtask

    task automatic t_remap();
        wr(`TDD_REG_CTRL, 32'h1);
        wr(8'h4C, 32'h19);
        rd(8'h4C, v);
        chk("remap_entry", 32'h19, v);
        run(5'h19, 5'h03, 5'h19, 26'h000_0100, 8'h18, 5'h03, 6'h02, 6'h01,
            5'h01);
        rd(`TDD_REG_STATUS, v);
        chk("status_remap", 32'h119, v);
        run(5'h10, 5'h10, 5'h10, 26'h000_0200, 8'h08, 5'h01, 6'h04, 6'h05,
            5'h04);
        rd(`TDD_REG_STATUS, v);
        chk("status_edge", 32'h010, v);
        wr(`TDD_REG_CTRL, 32'h0);
        run(5'h03, 5'h03, 5'h03, 26'h000_0300, 8'h10, 5'h03, 6'h00, 6'h07,
            5'h10);
        rd(`TDD_REG_STATUS, v);
        chk("status_direct", 32'h003, v);
        rd(`TDD_REG_COUNT, v);
        chk("count", 32'h6, v);
        $display("test remap done");
    endtask

    initial begin
        {rst, bld_store, go_launch, reg_wr, reg_rd} = 5'h10;
        {bld_single_flow, bld_fp_alt, bld_illegal_en} = 3'h0;
        {bld_mask_stack_en, bld_sw_en, bld_index, go_index} = 12'h000;
        {bld_kernel_ofs, bld_reg_count, bld_const_len, bld_const_ofs} = '0;
        {reg_addr, reg_wdata, gs} = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_fields();
        t_remap();
        stop_test();
    end
endmodule

`default_nettype wire
